// ==== src/dbc_map.vh ====
// constants, register offsets and field layouts of the output and bargraph settings block
//
// Contract
// - low clamp command stores a milliampere floor; negative values are refused
// - computed analog output never falls below the stored low clamp
// - flash-on command sets the flag that flashes the display on limit excess
// - flash-off command clears the limit flash flag
// - limit marks command with on or off shows or hides bargraph marks
// - bar format selects fill upward, fill downward or centre zero bidirectional
// - offset command stores signed offset, default zero, range -1999 to 9999
// - offset counts in milliamperes and is added to the analog output
// - default settings map a 4-20 mA input to the same 4-20 mA output
// - scale multiplier defaults to one; output equals scale times input plus offset
`ifndef DBC_MAP_VH
`define DBC_MAP_VH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define DBC_OFS_CTRL     12'h000
`define DBC_OFS_CLAMP    12'h004
`define DBC_OFS_OFFSET   12'h008
`define DBC_OFS_SCALE    12'h00C
`define DBC_OFS_INPUT    12'h010
`define DBC_OFS_OUTPUT   12'h014
`define DBC_OFS_STATUS   12'h018
`define DBC_OFS_MASK     12'h01C
`define DBC_OFS_CMD      12'h020
`define DBC_OFS_ADDR     12'h024

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define DBC_CTRL_FLASH   0
`define DBC_CTRL_MARKS   1
`define DBC_CTRL_FMT_LO  2
`define DBC_CTRL_FMT_HI  3

// bar format codes
`define DBC_FMT_UP       2'h0
`define DBC_FMT_DOWN     2'h1
`define DBC_FMT_BIDIR    2'h2

// ----------------------------------------------------------------
// command codes (bits 19:16 of the command word)
// ----------------------------------------------------------------
`define DBC_CMD_CLAMP    4'h1
`define DBC_CMD_FLASH_ON 4'h2
`define DBC_CMD_FLASH_OFF 4'h3
`define DBC_CMD_MARKS    4'h4
`define DBC_CMD_FORMAT   4'h5
`define DBC_CMD_OFFSET   4'h6
`define DBC_CMD_SCALE    4'h7

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define DBC_RST_CLAMP    16'sh0000
`define DBC_RST_OFFSET   16'sh0000
`define DBC_RST_SCALE    16'sh0001
`define DBC_OFS_MIN      (-16'sd1999)
`define DBC_OFS_MAX      16'sd9999
`define DBC_RST_UNIT     10'h000

// status bits
`define DBC_ST_ACCEPT    0
`define DBC_ST_REJECT    1
`define DBC_ST_ALIEN     2
`define DBC_ST_CLAMPED   3

`endif

// ==== src/dbc_out_calc.v ====
// analog output arithmetic: scale, offset and low clamp
`timescale 1ns/1ps
module dbc_out_calc #(
    parameter W = 16
) (
    input  wire                pclk,       // system clock
    input  wire                presetn,    // async reset, active low
    input  wire signed [W-1:0] in_ma,      // input value in mA
    input  wire signed [W-1:0] scale,      // multiplier
    input  wire signed [W-1:0] offset,     // offset in mA
    input  wire signed [W-1:0] clamp,      // low clamp in mA
    output reg  signed [W-1:0] out_r,      // output value in mA
    output reg                 clamped_r   // clamp active this cycle
);
    wire signed [2*W+1:0] in_x;
    wire signed [2*W+1:0] scale_x;
    wire signed [2*W+1:0] ofs_x;
    wire signed [2*W+1:0] prod;
    wire signed [2*W+1:0] sum;
    wire signed [2*W+1:0] clamp_x;
    wire signed [2*W+1:0] maxv;
    wire                  low;
    wire                  high;

    // scale times input
    // widened on purpose so the product and sum never wrap
    assign in_x    = {{(W+2){in_ma[W-1]}}, in_ma};
    assign scale_x = {{(W+2){scale[W-1]}}, scale};
    assign ofs_x   = {{(W+2){offset[W-1]}}, offset};
    assign prod = in_x * scale_x;
    assign sum = prod + ofs_x;
    assign clamp_x = {{(W+2){clamp[W-1]}}, clamp};
    assign maxv = {{(W+2){1'b0}}, 1'b0, {(W-1){1'b1}}};
    assign low = (sum < clamp_x);
    // saturate rather than wrap so large products stay monotonic
    assign high = (sum > maxv);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_r     <= {W{1'b0}};
            clamped_r <= 1'b0;
        end else begin
            clamped_r <= low;
            if (low) begin
                out_r <= clamp;
            end else if (high) begin
                out_r <= maxv[W-1:0];
            end else begin
                out_r <= sum[W-1:0];
            end
        end
    end
endmodule

// ==== src/dbc_sync.v ====
// two-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module dbc_sync #(
    parameter W = 1
) (
    input  wire         pclk,      // system clock
    input  wire         presetn,   // async reset, active low
    input  wire [W-1:0] d,         // asynchronous input
    output reg  [W-1:0] q_r        // synchronised output
);
    reg [W-1:0] meta_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= {W{1'b0}};
            q_r    <= {W{1'b0}};
        end else begin
            meta_r <= d;
            q_r    <= meta_r;
        end
    end
endmodule

// ==== src/dbc_settings.v ====
// command interpreter and settings store for analog output and bargraph
`timescale 1ns/1ps
`include "dbc_map.vh"
module dbc_settings #(
    parameter W = 16
) (
    input  wire                pclk,          // system clock, 20 MHz
    input  wire                presetn,       // async reset, active low
    input  wire                psel,          // apb select
    input  wire                penable,       // apb enable
    input  wire                pwrite,        // apb direction
    input  wire [11:0]         paddr,         // apb byte address
    input  wire [31:0]         pwdata,        // apb write data
    output reg  [31:0]         prdata,        // apb read data
    output reg                 pready,        // apb ready
    output reg                 pslverr,       // apb error
    input  wire signed [W-1:0] in_ma_pin,     // measured input in mA, asynchronous
    output reg  signed [W-1:0] out_ma_r,      // analog output value in mA
    output reg                 limit_flash_r, // flash display on limit excess
    output reg                 marks_on_r,    // bargraph limit marks shown
    output reg  [1:0]          bar_format_r,  // bargraph fill format
    output reg                 irq_r          // interrupt, active high level
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_ACC  = 1'b1;

    reg                st_r;
    reg signed [W-1:0] clamp_r;
    reg signed [W-1:0] offset_r;
    reg signed [W-1:0] scale_r;
    reg [9:0]          unit_r;
    reg [3:0]          status_r;
    reg [3:0]          mask_r;
    reg [3:0]          status_nxt;
    reg [3:0]          ev_set;
    reg                clamped_d_r;

    wire signed [W-1:0] in_sync;
    wire signed [W-1:0] calc_out;
    wire                calc_clamped;
    wire                wr_en;
    wire                rd_en;
    wire                is_cmd;
    wire [9:0]          cmd_unit;
    wire [3:0]          cmd_code;
    wire signed [W-1:0] cmd_arg;
    wire                unit_ok;
    wire                addr_ok;

    // ----------------------------------------------------------------
    // submodules
    // ----------------------------------------------------------------
    dbc_sync #(
        .W (W)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (in_ma_pin),
        .q_r     (in_sync)
    );

    dbc_out_calc #(
        .W (W)
    ) u_calc (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_ma     (in_sync),
        .scale     (scale_r),
        .offset    (offset_r),
        .clamp     (clamp_r),
        .out_r     (calc_out),
        .clamped_r (calc_clamped)
    );

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    assign wr_en = psel & penable & pwrite & pready;
    assign rd_en = psel & ~penable & ~pwrite;
    assign addr_ok = (paddr == `DBC_OFS_CTRL) || (paddr == `DBC_OFS_CLAMP) ||
                     (paddr == `DBC_OFS_OFFSET) || (paddr == `DBC_OFS_SCALE) ||
                     (paddr == `DBC_OFS_INPUT) || (paddr == `DBC_OFS_OUTPUT) ||
                     (paddr == `DBC_OFS_STATUS) || (paddr == `DBC_OFS_MASK) ||
                     (paddr == `DBC_OFS_CMD) || (paddr == `DBC_OFS_ADDR);

    // command word: [31:22] unit address, [19:16] code, [15:0] argument
    assign is_cmd   = wr_en && (paddr == `DBC_OFS_CMD);
    assign cmd_unit = pwdata[31:22];
    assign cmd_code = pwdata[19:16];
    assign cmd_arg  = pwdata[W-1:0];
    assign unit_ok  = (cmd_unit == unit_r);

    // registered ready in the first access cycle, no wait state, keeps the answer at a fixed two cycles
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r    <= ST_IDLE;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    pready  <= 1'b0;
                    pslverr <= 1'b0;
                    if (psel && !penable) begin
                        st_r    <= ST_ACC;
                        pready  <= 1'b1;
                        pslverr <= ~addr_ok;
                        prdata  <= 32'h0000_0000;
                        if (rd_en) begin
                            if (paddr == `DBC_OFS_CTRL) begin
                                prdata <= {28'h000_0000, bar_format_r,
                                           marks_on_r, limit_flash_r};
                            end else if (paddr == `DBC_OFS_CLAMP) begin
                                prdata <= {{(32-W){clamp_r[W-1]}}, clamp_r};
                            end else if (paddr == `DBC_OFS_OFFSET) begin
                                prdata <= {{(32-W){offset_r[W-1]}}, offset_r};
                            end else if (paddr == `DBC_OFS_SCALE) begin
                                prdata <= {{(32-W){scale_r[W-1]}}, scale_r};
                            end else if (paddr == `DBC_OFS_INPUT) begin
                                prdata <= {{(32-W){in_sync[W-1]}}, in_sync};
                            end else if (paddr == `DBC_OFS_OUTPUT) begin
                                prdata <= {{(32-W){out_ma_r[W-1]}}, out_ma_r};
                            end else if (paddr == `DBC_OFS_STATUS) begin
                                prdata <= {28'h000_0000, status_r};
                            end else if (paddr == `DBC_OFS_MASK) begin
                                prdata <= {28'h000_0000, mask_r};
                            end else if (paddr == `DBC_OFS_ADDR) begin
                                prdata <= {22'h00_0000, unit_r};
                            end
                        end
                    end
                end
                default: begin
                    st_r    <= ST_IDLE;
                    pready  <= 1'b0;
                    pslverr <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // settings store and command execution
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clamp_r       <= `DBC_RST_CLAMP;
            offset_r      <= `DBC_RST_OFFSET;
            scale_r       <= `DBC_RST_SCALE;
            unit_r        <= `DBC_RST_UNIT;
            mask_r        <= 4'h0;
            limit_flash_r <= 1'b0;
            marks_on_r    <= 1'b0;
            bar_format_r  <= `DBC_FMT_UP;
            ev_set        <= 4'h0;
        end else begin
            ev_set <= 4'h0;
            if (wr_en && !pslverr) begin
                if (paddr == `DBC_OFS_MASK) begin
                    mask_r <= pwdata[3:0];
                end else if (paddr == `DBC_OFS_ADDR) begin
                    unit_r <= pwdata[9:0];
                end
            end
            if (is_cmd && !unit_ok) begin
                ev_set[`DBC_ST_ALIEN] <= 1'b1;
            end else if (is_cmd) begin
                ev_set[`DBC_ST_ACCEPT] <= 1'b1;
                case (cmd_code)
                    `DBC_CMD_CLAMP: begin
                        if (cmd_arg[W-1]) begin
                            ev_set <= 4'h2;
                        end else begin
                            clamp_r <= cmd_arg;
                        end
                    end
                    `DBC_CMD_FLASH_ON: limit_flash_r <= 1'b1;
                    `DBC_CMD_FLASH_OFF: limit_flash_r <= 1'b0;
                    `DBC_CMD_MARKS: marks_on_r <= cmd_arg[0];
                    `DBC_CMD_FORMAT: begin
                        if (cmd_arg[1:0] == 2'h3) begin
                            ev_set <= 4'h2;
                        end else begin
                            bar_format_r <= cmd_arg[1:0];
                        end
                    end
                    `DBC_CMD_OFFSET: begin
                        if (cmd_arg < `DBC_OFS_MIN || cmd_arg > `DBC_OFS_MAX) begin
                            ev_set <= 4'h2;
                        end else begin
                            offset_r <= cmd_arg;
                        end
                    end
                    `DBC_CMD_SCALE: begin
                        if (cmd_arg < `DBC_OFS_MIN || cmd_arg > `DBC_OFS_MAX) begin
                            ev_set <= 4'h2;
                        end else begin
                            scale_r <= cmd_arg;
                        end
                    end
                    default: ev_set <= 4'h2;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // output, status and interrupt
    // ----------------------------------------------------------------
    always @* begin
        status_nxt = status_r;
        if (wr_en && paddr == `DBC_OFS_STATUS) begin
            status_nxt = status_r & ~pwdata[3:0];
        end
        // set wins over a simultaneous clear
        status_nxt = status_nxt | ev_set;
        if (calc_clamped && !clamped_d_r) begin
            status_nxt[`DBC_ST_CLAMPED] = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r    <= 4'h0;
            clamped_d_r <= 1'b0;
            out_ma_r    <= {W{1'b0}};
            irq_r       <= 1'b0;
        end else begin
            status_r    <= status_nxt;
            clamped_d_r <= calc_clamped;
            out_ma_r    <= calc_out;
            irq_r       <= |(status_nxt & mask_r);
        end
    end
endmodule

// ==== verification/dbc_host.sv ====
// host model: apb master that issues settings commands
`timescale 1ns/1ps
`include "dbc_map.vh"
module dbc_host (
    input  wire        pclk,    // clock
    output reg         psel,    // apb select
    output reg         penable, // apb enable
    output reg         pwrite,  // apb direction
    output reg  [11:0] paddr,   // apb address
    output reg  [31:0] pwdata,  // apb write data
    input  wire [31:0] prdata,  // apb read data
    input  wire        pready,  // apb ready
    input  wire        pslverr  // apb error
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // --------------------------------
    // one transfer, held until ready
    // --------------------------------
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // flipped so stale data never looks valid
        pwdata  <= ~d;
    endtask
    task automatic cmd(input logic [9:0] u, input logic [3:0] c, input logic [15:0] v);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, `DBC_OFS_CMD, {u, 2'b00, c, v}, r, e);
    endtask
endmodule

// ==== verification/dbc_settings_props.sv ====
// port assertions for the settings block
`timescale 1ns/1ps
`include "dbc_map.vh"
module dbc_settings_props #(
    parameter W = 16
) (
    input wire                pclk,          // clock
    input wire                presetn,       // reset, low
    input wire                psel,          // select
    input wire                penable,       // enable
    input wire                pwrite,        // direction
    input wire [11:0]         paddr,         // address
    input wire [31:0]         pwdata,        // write data
    input wire [31:0]         prdata,        // read data
    input wire                pready,        // ready
    input wire                pslverr,       // error
    input wire signed [W-1:0] in_ma_pin,     // input mA
    input wire signed [W-1:0] out_ma_r,      // output mA
    input wire                limit_flash_r, // flash flag
    input wire                marks_on_r,    // marks flag
    input wire [1:0]          bar_format_r,  // bar format
    input wire                irq_r          // interrupt
);
    reg  [9:0]  unit_r;
    reg  [15:0] arg_r;
    reg  signed [W-1:0] clamp_sh;
    wire        wr_done = psel && penable && pready && pwrite;
    wire        to_cmd  = wr_done && paddr == `DBC_OFS_CMD;
    wire        own     = to_cmd && pwdata[31:22] == unit_r;
    wire [3:0]  code    = pwdata[19:16];
    // shadow of the unit address so foreign frames can be told apart
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_r <= 10'h000;
            arg_r  <= 16'h0000;
            clamp_sh <= {W{1'b0}};
        end else begin
            if (wr_done && paddr == `DBC_OFS_ADDR) unit_r <= pwdata[9:0];
            if (own) arg_r <= pwdata[15:0];
            if (own && code == `DBC_CMD_CLAMP && !pwdata[W-1]) clamp_sh <= pwdata[W-1:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_READY_ANSWER: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("ready held too long");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
    // the new floor reaches the output two edges after the command
    AST_OUT_FLOOR: assert property (out_ma_r >= $past(clamp_sh, 2))
        else $error("output below floor");
    AST_FLASH_ON: assert property (own && code == `DBC_CMD_FLASH_ON |-> ##[1:2] limit_flash_r)
        else $error("flash not set");
    AST_FLASH_OFF: assert property (own && code == `DBC_CMD_FLASH_OFF |-> ##[1:2] !limit_flash_r)
        else $error("flash not cleared");
    AST_MARKS: assert property (own && code == `DBC_CMD_MARKS |-> ##[1:2] marks_on_r == arg_r[0])
        else $error("marks wrong");
    AST_FMT: assert property (own && code == `DBC_CMD_FORMAT && pwdata[15:0] < 16'h0003
        |-> ##[1:2] bar_format_r == arg_r[1:0])
        else $error("format wrong");
    AST_FMT_LEGAL: assert property (bar_format_r != 2'h3)
        else $error("illegal format");
    AST_ALIEN: assert property (to_cmd && !own |=> $stable({limit_flash_r, marks_on_r, bar_format_r})[*2])
        else $error("foreign frame changed settings");
    cover property (own && code == `DBC_CMD_FLASH_ON);
    cover property (to_cmd && !own);
    cover property ($rose(irq_r));
endmodule
bind dbc_settings dbc_settings_props #(.W(W)) dbc_settings_props_inst (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .in_ma_pin, .out_ma_r,
    .limit_flash_r, .marks_on_r, .bar_format_r, .irq_r);

// ==== verification/dbc_settings_test.sv ====
// self-checking bench for the settings block
`timescale 1ns/1ps
`include "dbc_map.vh"
module dbc_settings_test;
    reg               pclk;
    reg               presetn;
    reg signed [15:0] in_ma_pin;
    wire              psel, penable, pwrite, pready, pslverr;
    wire [11:0]       paddr;
    wire [31:0]       pwdata, prdata;
    wire signed [15:0] out_ma_r;
    wire              limit_flash_r, marks_on_r, irq_r;
    wire [1:0]        bar_format_r;
    int               num_errors, checks, i;
    int               m_clamp, m_ofs, m_scale, m_flash, m_marks, m_fmt, m_unit, m_st, m_mask;
    int               vals[$] = '{4, 20, 0, 12};
    int               ovals[$] = '{9999, 10000, -2000, -1999};
    logic [31:0]      rd;
    logic             er;
    logic [15:0]      lfsr;
    always #25 pclk = ~pclk;
    dbc_settings #(.W(16)) dbc_settings_inst (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .in_ma_pin, .out_ma_r, .limit_flash_r,
        .marks_on_r, .bar_format_r, .irq_r);
    dbc_host dbc_host_inst (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr);
    // --------------------------------
    // model and shared tasks
    // --------------------------------
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        checks++;
        if (s !== x) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, x, s);
        end
    endtask
    function automatic int calc(input int v);
        int o;
        o = m_scale * v + m_ofs;
        if (o < m_clamp) o = m_clamp;
        if (o > 32767) o = 32767;
        return o;
    endfunction
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic drive(input int v);
        @(posedge pclk);
        in_ma_pin <= v[15:0];
        repeat (6) @(posedge pclk);
        #1 chk("out_ma", 32'(out_ma_r), calc(v));
    endtask
    task automatic rdchk(input string n, input logic [11:0] a, input logic [15:0] x);
        dbc_host_inst.xfer(1'b0, a, 32'h0000_0000, rd, er);
        chk(n, rd[15:0], x);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        dbc_host_inst.xfer(1'b1, a, d, rd, er);
    endtask
    task automatic send(input int u, input int c, input int a);
        if (u != m_unit) m_st |= 4;
        else if (c == 1 && a >= 0) m_clamp = a;
        else if (c == 2) m_flash = 1;
        else if (c == 3) m_flash = 0;
        else if (c == 4) m_marks = a & 1;
        else if (c == 5 && a >= 0 && a <= 2) m_fmt = a;
        else if (c == 6 && a >= -1999 && a <= 9999) m_ofs = a;
        else if (c == 7 && a >= -1999 && a <= 9999) m_scale = a;
        else m_st |= 2;
        dbc_host_inst.cmd(u[9:0], c[3:0], a[15:0]);
        repeat (2) @(posedge pclk);
        #1 chk("flash", limit_flash_r, m_flash);
        chk("marks", marks_on_r, m_marks);
        chk("format", bar_format_r, m_fmt);
        dbc_host_inst.xfer(1'b0, `DBC_OFS_STATUS, 32'h0000_0000, rd, er);
        chk("status", rd & 32'h0000_0006, m_st & 6);
        #1 chk("irq", irq_r, (m_st & m_mask) != 0);
    endtask
    task automatic results();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #500_000;
        num_errors++;
        results();
    end
    // --------------------------------
    // scenarios
    // --------------------------------
    initial begin
        {pclk, presetn, in_ma_pin, m_clamp, m_ofs, m_flash, m_marks, m_fmt} = '0;
        {m_unit, m_st, m_mask, num_errors, checks} = '0;
        m_scale = 1;
        lfsr = 16'h0005;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("ctrl", `DBC_OFS_CTRL, 16'h0000);
        rdchk("clamp", `DBC_OFS_CLAMP, 16'h0000);
        rdchk("offset", `DBC_OFS_OFFSET, 16'h0000);
        rdchk("scale", `DBC_OFS_SCALE, 16'h0001);
        foreach (vals[i]) drive(vals[i]);
        repeat (4) begin
            lfsr = lfsr_next(lfsr);
            drive(int'(lfsr % 16'd21));
        end
        send(0, 6, 4);
        drive(4);
        foreach (ovals[i]) begin
            send(0, 6, ovals[i]);
            rdchk("offset", `DBC_OFS_OFFSET, m_ofs[15:0]);
        end
        drive(4);
        send(0, 1, 2);
        drive(4);
        send(0, 1, -1);
        rdchk("clamp", `DBC_OFS_CLAMP, m_clamp[15:0]);
        drive(0);
        send(0, 6, 0);
        send(0, 7, 2);
        send(0, 7, 10000);
        drive(4);
        wr(`DBC_OFS_SCALE, 32'h0000_0005);
        rdchk("scale", `DBC_OFS_SCALE, 16'h0002);
        send(0, 2, 0);
        send(0, 3, 0);
        send(0, 4, 1);
        send(0, 4, 0);
        for (i = 0; i < 4; i++) send(0, 5, i);
        send(0, 0, 0);
        m_mask = 6;
        wr(`DBC_OFS_MASK, 32'h0000_0006);
        // new mask lands on the write edge, irq follows one edge later
        @(posedge pclk);
        #1 chk("irq", irq_r, (m_st & m_mask) != 0);
        m_st &= ~6;
        wr(`DBC_OFS_STATUS, 32'h0000_0006);
        @(posedge pclk);
        #1 chk("irq", irq_r, 1'b0);
        m_unit = 5;
        wr(`DBC_OFS_ADDR, 32'h0000_0005);
        send(0, 2, 0);
        m_mask = 0;
        wr(`DBC_OFS_MASK, 32'h0000_0000);
        send(5, 2, 0);
        dbc_host_inst.xfer(1'b0, 12'h030, 32'h0000_0000, rd, er);
        chk("unmapped_err", er, 1'b1);
        chk("unmapped_data", rd, 32'h0000_0000);
        results();
    end
endmodule
